/* verilog/ccrtc_params.svh */
/*
  Register indices, field positions, reset values and calendar limits of the real-time clock.
  Assumes inclusion by bare name from the clock's design files.
*/
`ifndef CCRTC_PARAMS_SVH
`define CCRTC_PARAMS_SVH

// Word indices on the register bus
`define CCRTC_SECONDS_COUNT_REGISTER 4'h0
`define CCRTC_MINUTES_COUNT_REGISTER 4'h1
`define CCRTC_HOURS_COUNT_REGISTER 4'h2
`define CCRTC_DAY_OF_WEEK_REGISTER 4'h3
`define CCRTC_DAY_OF_MONTH_REGISTER 4'h4
`define CCRTC_MONTH_COUNT_REGISTER 4'h5
`define CCRTC_YEAR_COUNT_REGISTER 4'h6
`define CCRTC_SECONDS_ALARM_REGISTER 4'h7
`define CCRTC_MINUTES_ALARM_REGISTER 4'h8
`define CCRTC_HOURS_ALARM_REGISTER 4'h9
`define CCRTC_DOW_ALARM_REGISTER 4'hA
`define CCRTC_DOM_ALARM_REGISTER 4'hB
`define CCRTC_ALARM_ENABLE_REGISTER 4'hC
`define CCRTC_TIMING_CONFIG_REG 4'hD
`define CCRTC_LOCK_CONTROL_REGISTER 4'hE
`define CCRTC_DIRECT_PRESCALE_REGISTER 4'hF

// Field positions
`define CCRTC_TIM_MODE_BIT 4
`define CCRTC_TIM_BCD_BIT 5
`define CCRTC_CTRL_LOCK_BIT 0
`define CCRTC_CTRL_ALARM_BIT 1
`define CCRTC_CTRL_SYNC_BIT 2

// Source and prescale codes
`define CCRTC_SRC_XTAL 2'h0
`define CCRTC_SRC_WATCHDOG_OSC 2'h1
`define CCRTC_SRC_SYSTEM_CLOCK 2'h2
`define CCRTC_SRC_EVENT_IN 2'h3
`define CCRTC_FREQ_32K 2'h0
`define CCRTC_FREQ_50HZ 2'h1
`define CCRTC_FREQ_60HZ 2'h2
`define CCRTC_FREQ_DIRECT 2'h3

// Source rates and the derived terminal counts for one tick per second
`define CCRTC_XTAL_HZ 32768
`define CCRTC_MAINS50_HZ 50
`define CCRTC_MAINS60_HZ 60
`define CCRTC_TERM_32K (16'(`CCRTC_XTAL_HZ - 1))
`define CCRTC_TERM_50HZ (16'(`CCRTC_MAINS50_HZ - 1))
`define CCRTC_TERM_60HZ (16'(`CCRTC_MAINS60_HZ - 1))

// Calendar limits in binary
`define CCRTC_ZERO 7'h00
`define CCRTC_ONE 7'h01
`define CCRTC_SEC_MAX 7'h3B
`define CCRTC_HRS_MAX 7'h17
`define CCRTC_DOW_MAX 7'h07
`define CCRTC_MON_MAX 7'h0C
`define CCRTC_YEAR_MAX 7'h63
`define CCRTC_FEB 7'h02
`define CCRTC_DAYS_28 7'h1C
`define CCRTC_DAYS_30 7'h1E
`define CCRTC_DAYS_31 7'h1F
`define CCRTC_MONTH_30_MASK 13'h0A50
`define CCRTC_TEN 7'h0A

// Reset values
`define CCRTC_RESET_COUNT 8'h00
`define CCRTC_RESET_PRESCALE 16'h0000

`endif

/* verilog/ccrtc_pkg.sv */
/*
  Types shared by the real-time clock design files.
  Assumes nothing of its surroundings.
*/
package ccrtc_pkg;

  typedef enum logic {
    CCRTC_IDLE,
    CCRTC_ANSWER
  } ccrtc_bus_state_t;

endpackage

/* verilog/ccrtc_field_inc.sv */
/*
  One calendar field incrementer: binary or BCD value in, next value and wrap flag out.
  Assumes the value is within lo..hi in the selected format.
*/
`timescale 1ns/100ps
`include "ccrtc_params.svh"

module ccrtc_field_inc (
  input wire logic [7:0] value,
  input wire logic bcd,
  input wire logic [6:0] lo,
  input wire logic [6:0] hi,
  output logic [7:0] next_value,
  output logic wrap
);

  logic [6:0] bin;
  logic [6:0] next_bin;

  always_comb begin
    bin = bcd ? (7'(value[7:4]) * `CCRTC_TEN + 7'(value[3:0])) : value[6:0];
    wrap = (bin >= hi);
    next_bin = wrap ? lo : 7'(bin + `CCRTC_ONE);
    if (bcd) begin
      next_value = {1'b0, 3'(next_bin / `CCRTC_TEN), 4'(next_bin % `CCRTC_TEN)};
    end else begin
      next_value = {1'b0, next_bin};
    end
  end

endmodule

/* verilog/ccrtc_prescaler.sv */
/*
  Prescaler: counts source pulses up to a terminal value and emits one tick per wrap.
  Assumes src_pulse is a one-cycle pulse in the clk domain.
*/
`timescale 1ns/100ps
`include "ccrtc_params.svh"

module ccrtc_prescaler (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic run,
  input wire logic src_pulse,
  input wire logic [15:0] terminal,
  output logic tick,
  output logic near_end
);

  logic [15:0] count;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      count <= `CCRTC_RESET_PRESCALE;
      tick <= 1'b0;
    end else if (!run) begin
      count <= `CCRTC_RESET_PRESCALE;
      tick <= 1'b0;
    end else if (src_pulse) begin
      tick <= (count >= terminal);
      count <= (count >= terminal) ? `CCRTC_RESET_PRESCALE : 16'(count + 16'h0001);
    end else begin
      tick <= 1'b0;
    end
  end

  // Next source pulse will produce a tick
  assign near_end = run && (count >= terminal);

endmodule

/* verilog/ccrtc_top.sv */
/*
  Real-time clock with calendar and 32-bit counter modes, alarm matching and lock control,
  reached over an Avalon-MM slave with waitrequest.
  Assumes one 40 MHz clock; source pins are synchronised here before use.
*/
// Added by the designer: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/100ps
`include "ccrtc_params.svh"

// What this block does
// - Mode 0 counts seconds to year, hours in 24-hour form.
// - Count and alarm values are binary or BCD by format bit.
// - Day of month wraps by month length; no leap-year correction.
// - Mode 1 counts 32 bits: seconds MSB, minutes, hours, day-of-month LSB.
// - Counter mode alarm bytes are seconds, minutes, hours and day-of-month alarms.
// - Calendar alarms exist for seconds, minutes, hours, day-of-week, day-of-month.
// - Alarm holds only when every enabled field matches; disabled ignored.
// - Alarm status holds the result of the last comparison and drives the interrupt request.
// - Alarm comparison happens on each count increment.
// - Writing one to lock forces a comparison, even if already set.
// - Alarm value and enable registers are writable regardless of lock.
// - Automatic prescale settings give exactly one increment per second.
// - Source select: 00 crystal, 01 watchdog oscillator, 10 system, 11 event.
// - Prescale select 00 is automatic 32.768 kHz; 11 uses programmed value.
// - Prescale select 01 and 10 are automatic 50 Hz and 60 Hz.
// - Lock 0 stops counting, allows writes; lock 1 counts, blocks count, timing and direct prescale writes.
// - Lock resets to 0, so counting starts stopped.
// - Alarm enables reset cleared; counts need no defined reset value.
// - Prescaler held in reset while unlocked, runs when locked.
// - Automatic prescale: sync flag low only while counts are stable.
// - Direct prescale while locked: sync flag held high.
// - Unlocked: sync flag cleared.
module ccrtc_top (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic xtal_32k_source,
  input wire logic watchdog_osc_source,
  input wire logic event_in_source,
  output logic alarm_irq
);

  ccrtc_pkg::ccrtc_bus_state_t bus_state;
  logic [7:0] cnt [0:6];
  logic [7:0] alarm_val [0:4];
  logic [4:0] alarm_en;
  logic [1:0] clk_sel;
  logic [1:0] prescale_frequency_select;
  logic mode;
  logic bcd;
  logic lock;
  logic [15:0] direct_prescale;
  logic alarm_status;
  logic sync_flag;
  logic compare_pending;
  logic [2:0] pin_meta;
  logic [2:0] pin_sync;
  logic [2:0] pin_last;
  logic [2:0] pin_rise;
  logic src_pulse;
  logic [15:0] terminal;
  logic presc_tick;
  logic near_end;
  logic count_tick;
  logic req;
  logic wr_fire;
  logic lock_wr_one;
  logic [31:0] next_readdata;
  logic [6:0] lo_lim [0:6];
  logic [6:0] hi_lim [0:6];
  logic [7:0] fnext [0:6];
  logic [6:0] fwrap;
  logic [6:0] step;
  logic [6:0] mon_bin;
  logic [31:0] next_count32;
  logic [4:0] match;
  logic [4:0] en_eff;
  logic all_match;

  // Bus handshake: one wait cycle, answer in the second
  assign req = avs_read | avs_write;
  assign avs_waitrequest = req && (bus_state == ccrtc_pkg::CCRTC_IDLE);
  assign wr_fire = avs_write && (bus_state == ccrtc_pkg::CCRTC_ANSWER);
  assign lock_wr_one = wr_fire && (avs_address == `CCRTC_LOCK_CONTROL_REGISTER)
                       && avs_writedata[`CCRTC_CTRL_LOCK_BIT];

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bus_state <= ccrtc_pkg::CCRTC_IDLE;
    end else begin
      unique case (bus_state)
        ccrtc_pkg::CCRTC_IDLE: begin
          if (req) begin
            bus_state <= ccrtc_pkg::CCRTC_ANSWER;
          end
        end
        ccrtc_pkg::CCRTC_ANSWER: begin
          bus_state <= ccrtc_pkg::CCRTC_IDLE;
        end
      endcase
    end
  end

  always_comb begin
    next_readdata = 32'h0000_0000;
    case (avs_address)
      `CCRTC_SECONDS_COUNT_REGISTER,
      `CCRTC_MINUTES_COUNT_REGISTER,
      `CCRTC_HOURS_COUNT_REGISTER,
      `CCRTC_DAY_OF_WEEK_REGISTER,
      `CCRTC_DAY_OF_MONTH_REGISTER,
      `CCRTC_MONTH_COUNT_REGISTER,
      `CCRTC_YEAR_COUNT_REGISTER: next_readdata[7:0] = cnt[3'(avs_address)];
      `CCRTC_SECONDS_ALARM_REGISTER: next_readdata[7:0] = alarm_val[0];
      `CCRTC_MINUTES_ALARM_REGISTER: next_readdata[7:0] = alarm_val[1];
      `CCRTC_HOURS_ALARM_REGISTER: next_readdata[7:0] = alarm_val[2];
      `CCRTC_DOW_ALARM_REGISTER: next_readdata[7:0] = alarm_val[3];
      `CCRTC_DOM_ALARM_REGISTER: next_readdata[7:0] = alarm_val[4];
      `CCRTC_ALARM_ENABLE_REGISTER: next_readdata[4:0] = alarm_en;
      `CCRTC_TIMING_CONFIG_REG: next_readdata[5:0] = {bcd, mode, prescale_frequency_select, clk_sel};
      `CCRTC_LOCK_CONTROL_REGISTER: next_readdata[2:0] = {sync_flag, alarm_status, lock};
      default: next_readdata[15:0] = direct_prescale;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && (bus_state == ccrtc_pkg::CCRTC_IDLE)) begin
      avs_readdata <= next_readdata;
    end
  end

  // Control and timing registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      lock <= 1'b0;
      clk_sel <= `CCRTC_SRC_XTAL;
      prescale_frequency_select <= `CCRTC_FREQ_32K;
      mode <= 1'b0;
      bcd <= 1'b0;
      direct_prescale <= `CCRTC_RESET_PRESCALE;
    end else if (wr_fire) begin
      if (avs_address == `CCRTC_LOCK_CONTROL_REGISTER) begin
        lock <= avs_writedata[`CCRTC_CTRL_LOCK_BIT];
      end
      if (!lock && avs_address == `CCRTC_TIMING_CONFIG_REG) begin
        clk_sel <= avs_writedata[1:0];
        prescale_frequency_select <= avs_writedata[3:2];
        mode <= avs_writedata[`CCRTC_TIM_MODE_BIT];
        bcd <= avs_writedata[`CCRTC_TIM_BCD_BIT];
      end
      if (!lock && avs_address == `CCRTC_DIRECT_PRESCALE_REGISTER) begin
        direct_prescale <= avs_writedata[15:0];
      end
    end
  end

  // Alarm values and enables
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      alarm_en <= 5'h00;
      for (int i = 0; i < 5; i++) begin
        alarm_val[i] <= `CCRTC_RESET_COUNT;
      end
    end else if (wr_fire) begin
      if (avs_address == `CCRTC_ALARM_ENABLE_REGISTER) begin
        alarm_en <= avs_writedata[4:0];
      end
      for (int i = 0; i < 5; i++) begin
        if (avs_address == 4'(`CCRTC_SECONDS_ALARM_REGISTER + 4'(i))) begin
          alarm_val[i] <= avs_writedata[7:0];
        end
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_meta <= 3'h0;
      pin_sync <= 3'h0;
      pin_last <= 3'h0;
    end else begin
      pin_meta <= {event_in_source, watchdog_osc_source, xtal_32k_source};
      pin_sync <= pin_meta;
      pin_last <= pin_sync;
    end
  end

  generate
    for (genvar gp = 0; gp < 3; gp++) begin : g_edge
      assign pin_rise[gp] = pin_sync[gp] & ~pin_last[gp];
    end
  endgenerate

  always_comb begin
    unique case (clk_sel)
      `CCRTC_SRC_XTAL: src_pulse = pin_rise[0];
      `CCRTC_SRC_WATCHDOG_OSC: src_pulse = pin_rise[1];
      `CCRTC_SRC_SYSTEM_CLOCK: src_pulse = 1'b1;
      `CCRTC_SRC_EVENT_IN: src_pulse = pin_rise[2];
    endcase
  end

  always_comb begin
    unique case (prescale_frequency_select)
      `CCRTC_FREQ_32K: terminal = `CCRTC_TERM_32K;
      `CCRTC_FREQ_50HZ: terminal = `CCRTC_TERM_50HZ;
      `CCRTC_FREQ_60HZ: terminal = `CCRTC_TERM_60HZ;
      `CCRTC_FREQ_DIRECT: terminal = direct_prescale;
    endcase
  end

  ccrtc_prescaler u_prescaler (
    .clk(clk),
    .reset_n(reset_n),
    .run(lock),
    .src_pulse(src_pulse),
    .terminal(terminal),
    .tick(presc_tick),
    .near_end(near_end)
  );

  assign count_tick = presc_tick && lock;

  always_comb begin
    mon_bin = bcd ? (7'(cnt[5][7:4]) * `CCRTC_TEN + 7'(cnt[5][3:0])) : cnt[5][6:0];
    for (int i = 0; i < 7; i++) begin
      lo_lim[i] = `CCRTC_ZERO;
    end
    lo_lim[3] = `CCRTC_ONE;
    lo_lim[4] = `CCRTC_ONE;
    lo_lim[5] = `CCRTC_ONE;
    hi_lim[0] = `CCRTC_SEC_MAX;
    hi_lim[1] = `CCRTC_SEC_MAX;
    hi_lim[2] = `CCRTC_HRS_MAX;
    hi_lim[3] = `CCRTC_DOW_MAX;
    if (mon_bin == `CCRTC_FEB) begin
      hi_lim[4] = `CCRTC_DAYS_28;
    end else if (mon_bin <= `CCRTC_MON_MAX && 1'((`CCRTC_MONTH_30_MASK) >> mon_bin)) begin
      hi_lim[4] = `CCRTC_DAYS_30;
    end else begin
      hi_lim[4] = `CCRTC_DAYS_31;
    end
    hi_lim[5] = `CCRTC_MON_MAX;
    hi_lim[6] = `CCRTC_YEAR_MAX;
  end

  generate
    for (genvar gi = 0; gi < 7; gi++) begin : g_field
      ccrtc_field_inc u_inc (
        .value(cnt[gi]),
        .bcd(bcd),
        .lo(lo_lim[gi]),
        .hi(hi_lim[gi]),
        .next_value(fnext[gi]),
        .wrap(fwrap[gi])
      );
    end
  endgenerate

  always_comb begin
    step[0] = 1'b1;
    step[1] = fwrap[0];
    step[2] = step[1] & fwrap[1];
    step[3] = step[2] & fwrap[2];
    step[4] = step[3];
    step[5] = step[4] & fwrap[4];
    step[6] = step[5] & fwrap[5];
  end

  assign next_count32 = {cnt[0], cnt[1], cnt[2], cnt[4]} + 32'h0000_0001;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < 7; i++) begin
        cnt[i] <= `CCRTC_RESET_COUNT;
      end
    end else if (count_tick) begin
      if (mode) begin
        {cnt[0], cnt[1], cnt[2], cnt[4]} <= next_count32;
      end else begin
        for (int i = 0; i < 7; i++) begin
          if (step[i]) begin
            cnt[i] <= fnext[i];
          end
        end
      end
    end else if (wr_fire && !lock && avs_address <= `CCRTC_YEAR_COUNT_REGISTER) begin
      cnt[3'(avs_address)] <= avs_writedata[7:0];
    end
  end

  always_comb begin
    for (int i = 0; i < 5; i++) begin
      match[i] = (alarm_val[i] == cnt[i]);
    end
    en_eff = {alarm_en[4], alarm_en[3] & ~mode, alarm_en[2:0]};
    all_match = &(~en_eff | match);
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      compare_pending <= 1'b0;
      alarm_status <= 1'b0;
    end else begin
      compare_pending <= count_tick | lock_wr_one;
      if (compare_pending) begin
        alarm_status <= all_match;
      end
    end
  end

  assign alarm_irq = alarm_status;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sync_flag <= 1'b0;
    end else begin
      sync_flag <= lock && ((prescale_frequency_select == `CCRTC_FREQ_DIRECT) || near_end || presc_tick);
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  a_frozen_unlocked: assert property (!lock && !wr_fire |=> $stable(cnt[0]) && $stable(cnt[4]))
    else $error("count moved while unlocked");
  a_locked_write_ignored: assert property (lock && wr_fire && !count_tick
      && avs_address == `CCRTC_SECONDS_COUNT_REGISTER |=> $stable(cnt[0]))
    else $error("count written while locked");
  a_sync_unlocked: assert property (!lock |=> !sync_flag)
    else $error("sync set while unlocked");
  a_sync_direct: assert property ((lock && prescale_frequency_select == `CCRTC_FREQ_DIRECT) [*2] |-> sync_flag)
    else $error("sync low under direct prescale");
  a_alarm_compare: assert property (count_tick |=> compare_pending ##1 alarm_status == $past(all_match))
    else $error("alarm not compared after increment");
  a_lock_compare: assert property (lock_wr_one |=> compare_pending)
    else $error("lock write did not force compare");
  a_prescaler_held: assert property (!lock ##1 !lock |-> !presc_tick)
    else $error("prescaler ticked while unlocked");
  a_second_wrap: assert property (count_tick && !mode && !bcd && cnt[0] == {1'b0, `CCRTC_SEC_MAX}
      |=> cnt[0] == `CCRTC_RESET_COUNT && cnt[1] != $past(cnt[1]))
    else $error("seconds did not wrap");
  a_counter_carry: assert property (count_tick && mode && (&cnt[4]) && !(&cnt[2])
      |=> cnt[2] == 8'($past(cnt[2]) + 8'h01) && cnt[4] == `CCRTC_RESET_COUNT)
    else $error("counter byte carry wrong");
  a_feb_rollover: assert property (count_tick && !mode && !bcd && cnt[5] == {1'b0, `CCRTC_FEB}
      && cnt[4] == {1'b0, `CCRTC_DAYS_28} && (&step[4:0]) |=> cnt[4] == {1'b0, `CCRTC_ONE})
    else $error("february rollover wrong");
  a_alarm_writable: assert property (wr_fire && avs_address == `CCRTC_SECONDS_ALARM_REGISTER
      |=> alarm_val[0] == $past(avs_writedata[7:0]))
    else $error("alarm write lost");
  a_irq_follows: assert property (!compare_pending |=> $stable(alarm_irq))
    else $error("irq moved without a compare");

  c_counter_tick: cover property (count_tick && mode);
  c_alarm_rise: cover property (!alarm_status ##1 alarm_status);
  c_lock_rewrite: cover property (lock && lock_wr_one);
  c_calendar_carry: cover property (count_tick && !mode && step[3]);

endmodule

/* dv/tb_calendar_counter_rtc.sv */
/*
  Self-checking bench for the calendar and counter real-time clock.
  Assumes the design files under verilog/ are compiled first; the bench drives every port itself.
*/
`timescale 1ns/100ps

module tb_calendar_counter_rtc;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic alarm_irq;
  logic [3:0] src_cnt = 4'h0;
  logic xtal_32k_source;
  logic watchdog_osc_source;
  logic event_in_source;
  logic [31:0] rd;
  int mismatches = 0;
  int checked = 0;

  // Source pins: periods of 4, 8 and 16 clocks
  assign xtal_32k_source = src_cnt[1];
  assign watchdog_osc_source = src_cnt[2];
  assign event_in_source = src_cnt[3];

  ccrtc_top uut (
    .clk(clk),
    .reset_n(reset_n),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .xtal_32k_source(xtal_32k_source),
    .watchdog_osc_source(watchdog_osc_source),
    .event_in_source(event_in_source),
    .alarm_irq(alarm_irq)
  );

  initial begin
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk) begin
    src_cnt <= src_cnt + 4'h1;
  end

  task test_done;
    if (mismatches == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One Avalon transfer; waitrequest is sampled at each rising edge, the answer taken at the first edge it is low
  task bus(input logic wr_en, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr_en;
    avs_write <= wr_en;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (avs_waitrequest !== 1'b0) begin
      mismatches++;
      test_done;
    end
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task wr(input logic [3:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task rdchk(input logic [3:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(rd, exp);
  endtask

  task irqchk(input logic exp);
    repeat (3) @(posedge clk);
    check({31'h0, alarm_irq}, {31'h0, exp});
  endtask

  task set_counts(input logic [55:0] v);
    for (int i = 0; i < 7; i++) begin
      wr(i[3:0], {24'h0, v[55 - 8 * i -: 8]});
    end
  endtask

  task t_reset;
    rdchk(4'hE, 32'h0);
    rdchk(4'hC, 32'h0);
    check({31'h0, alarm_irq}, 32'h0);
  endtask

  // Preset counts, run to the next increment, stop and compare every count
  task roll(input logic [7:0] tim, input logic [3:0] pa, input logic [55:0] st, input logic [55:0] ex,
            input logic irq);
    logic [31:0] first;
    int n;
    wr(4'hE, 32'h0);
    wr(4'hD, {24'h0, tim});
    wr(4'hF, 32'h3E7);
    set_counts(st);
    wr(4'h7, 32'h0);
    wr(4'hC, {31'h0, irq});
    wr(4'hE, 32'h1);
    if (irq) irqchk(1'b0);
    bus(1'b0, pa, 32'h0);
    first = rd;
    n = 0;
    do begin
      bus(1'b0, pa, 32'h0);
      n++;
    end while (rd === first && n < 600);
    if (n >= 600) begin
      mismatches++;
      test_done;
    end
    wr(4'hE, 32'h0);
    for (int i = 0; i < 7; i++) begin
      bus(1'b0, i[3:0], 32'h0);
      check(rd, {24'h0, ex[55 - 8 * i -: 8]});
    end
    if (irq) check({31'h0, alarm_irq}, 32'h1);
  endtask

  task t_alarm;
    wr(4'hE, 32'h0);
    wr(4'hD, 32'h0E);
    wr(4'hF, 32'hFFFF);
    set_counts(56'h10200503150607);
    wr(4'h7, 32'h10);
    wr(4'h8, 32'h20);
    wr(4'h9, 32'h05);
    wr(4'hA, 32'h03);
    wr(4'hB, 32'h15);
    wr(4'hC, 32'h1F);
    wr(4'hE, 32'h1);
    irqchk(1'b1);
    rdchk(4'hE, 32'h7);
    wr(4'h8, 32'h21);
    rdchk(4'h8, 32'h21);
    wr(4'hE, 32'h1);
    irqchk(1'b0);
    wr(4'hC, 32'h1D);
    wr(4'hE, 32'h1);
    irqchk(1'b1);
    wr(4'h0, 32'h55);
    rdchk(4'h0, 32'h10);
    wr(4'hD, 32'h00);
    rdchk(4'hD, 32'h0E);
    wr(4'hF, 32'h0);
    rdchk(4'hF, 32'hFFFF);
    wr(4'h8, 32'h20);
    wr(4'hA, 32'h06);
    wr(4'hC, 32'h1F);
    wr(4'hE, 32'h1);
    irqchk(1'b0);
    // Counter mode drops the weekday byte from matching
    wr(4'hE, 32'h0);
    wr(4'hD, 32'h1E);
    wr(4'hE, 32'h1);
    irqchk(1'b1);
    wr(4'hE, 32'h0);
    bus(1'b0, 4'hE, 32'h0);
    check(rd & 32'h5, 32'h0);
  endtask

  // Count from a given source and prescale for a fixed time, expecting two increments
  task run(input logic [7:0] tim, input logic [15:0] term, input int cyc, input logic sy);
    wr(4'hE, 32'h0);
    wr(4'hD, {24'h0, tim});
    wr(4'hF, {16'h0, term});
    wr(4'h0, 32'h0);
    wr(4'h1, 32'h0);
    wr(4'hE, 32'h1);
    bus(1'b0, 4'hE, 32'h0);
    check({31'h0, rd[2]}, {31'h0, sy});
    repeat (cyc) @(posedge clk);
    wr(4'hE, 32'h0);
    rdchk(4'h0, 32'h2);
    repeat (300) @(posedge clk);
    rdchk(4'h0, 32'h2);
  endtask

  initial begin
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    t_reset;
    t_alarm;
    roll(8'h0E, 4'h0, 56'h3B3B17071F0C63, 56'h00000001010100, 1'b1);
    roll(8'h0E, 4'h0, 56'h3B3B17031C0204, 56'h00000004010304, 1'b0);
    roll(8'h0E, 4'h0, 56'h3B3B17021E0405, 56'h00000003010505, 1'b0);
    roll(8'h2E, 4'h0, 56'h59592307311299, 56'h00000001010100, 1'b0);
    roll(8'h2E, 4'h0, 56'h59590902090919, 56'h00001002090919, 1'b0);
    roll(8'h1E, 4'h4, 56'h00FFFF07FF0C63, 56'h01000007000C63, 1'b0);
    roll(8'h1E, 4'h4, 56'h12345607FF0C63, 56'h12345707000C63, 1'b0);
    run(8'h0C, 16'h9, 100, 1'b1);
    run(8'h09, 16'h0, 1200, 1'b0);
    run(8'h07, 16'h0, 2000, 1'b0);
    run(8'h0E, 16'h63, 250, 1'b1);
    run(8'h02, 16'h0, 66000, 1'b0);
    test_done;
  end

  initial begin
    repeat (100000) @(posedge clk);
    mismatches++;
    test_done;
  end
endmodule
